// [core/tpc_consts.vh]
// Constants for the timer prescaler counter block
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH
`define TPC_ADDR_W        12
`define TPC_OFF_CTRL      12'h000
`define TPC_OFF_CNT_HI    12'h004
`define TPC_OFF_CNT_LO    12'h008
`define TPC_OFF_STATUS    12'h00C
`define TPC_PS_LSB        0
`define TPC_PS_MSB        2
`define TPC_CLR_BIT       3
`define TPC_PS_EXT        3'h7
`define TPC_DIV_W         6
`define TPC_CNT_W         16
`define TPC_CNT_RST       16'h0000
`define TPC_BYTE_RST      8'h00
`define TPC_WORD_ZERO     32'h0000_0000
`define TPC_PS_RST        3'h0
`define TPC_HI_MSB        15
`define TPC_HI_LSB        8
`define TPC_LO_MSB        7
`define TPC_LO_LSB        0
`define TPC_LATCH_BIT     0
`endif

// [core/tpc_prescaler.v]
// Prescaler and tick source selection for the timer prescaler counter
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.vh"
module tpc_prescaler
(
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire [2:0] prescale_select_i,
  input  wire       timer_external_clock_in_i,
  input  wire       clear_i,
  output reg        tick_o
);
  reg  [`TPC_DIV_W-1:0] div_r;
  reg                   ext_q_r;
  reg                   ext_d_r;
  reg                   ext_e_r;
  wire [`TPC_DIV_W:0]   stages;
  wire                  int_tick;
  // One stage per power of two; stage k fires when the low k divider bits are all ones
  assign stages[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < `TPC_DIV_W; g = g + 1)
    begin : g_stage
      assign stages[g+1] = stages[g] & div_r[g];
    end
  endgenerate
  assign int_tick = stages[prescale_select_i];
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_r   <= {`TPC_DIV_W{1'b0}};
      ext_q_r <= 1'b0;
      ext_d_r <= 1'b0;
      ext_e_r <= 1'b0;
      tick_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_q_r <= timer_external_clock_in_i;
      ext_d_r <= ext_q_r;
      // Edge found behind the second stage so only it reads the first
      ext_e_r <= ext_d_r;
      // Clearing restarts the division so the first count after clear takes a full period
      if (clear_i)
        div_r <= {`TPC_DIV_W{1'b0}};
      else
        div_r <= div_r + {{(`TPC_DIV_W-1){1'b0}}, 1'b1};
      if (prescale_select_i == `TPC_PS_EXT)
        tick_o <= ext_d_r & ~ext_e_r & ~clear_i;
      else
        tick_o <= int_tick & ~clear_i;
    end
  end
endmodule // tpc_prescaler
`default_nettype wire

// [core/tpc_timer.v]
// Top of the timer prescaler counter with its APB register slave
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.vh"
module tpc_timer
(
  input  wire                   clock_i,
  input  wire                   rst_i,
  input  wire                   ce_i,
  input  wire                   timer_external_clock_in_i,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`TPC_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  output reg  [`TPC_CNT_W-1:0]  count_o
);
  ////////////////////////////////////////////////////////////////////////////////
  reg  [2:0]            prescale_select_r;
  reg                   clear_r;
  reg  [7:0]            low_buf_r;
  reg                   latched_r;
  reg                   phase_r;
  reg                   phase_nxt;
  wire                  tick;
  wire                  setup;
  wire                  access;
  wire                  hit_ctrl;
  wire                  hit_hi;
  wire                  hit_lo;
  wire                  hit_stat;
  wire                  wr_ctrl;
  wire                  rd_hi;
  wire                  rd_lo;
  wire                  mapped;
  reg  [31:0]           rdata_nxt;

  // Bus phase: a setup edge arms the tracker, the completing access edge disarms it
  localparam PH_IDLE = 1'b0;
  localparam PH_ACC  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, one hit per register word
  assign hit_ctrl = (paddr == `TPC_OFF_CTRL);
  assign hit_hi   = (paddr == `TPC_OFF_CNT_HI);
  assign hit_lo   = (paddr == `TPC_OFF_CNT_LO);
  assign hit_stat = (paddr == `TPC_OFF_STATUS);
  assign mapped   = hit_ctrl | hit_hi | hit_lo | hit_stat;

  // Reads act at setup so the captured low byte belongs to the high byte returned
  assign setup    = psel & ~penable & ce_i;
  // Writes wait for the edge that completes the access, so an aborted transfer changes nothing
  assign access   = psel & penable & pready & (phase_r == PH_ACC) & ce_i;
  assign wr_ctrl  = access & pwrite & hit_ctrl & pstrb[0];
  assign rd_hi    = setup & ~pwrite & hit_hi;
  assign rd_lo    = setup & ~pwrite & hit_lo;

  always @*
  begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_IDLE: if (setup) phase_nxt = PH_ACC;
      PH_ACC:  if (access) phase_nxt = PH_IDLE;
      default: phase_nxt = PH_IDLE;
    endcase
  end

  tpc_prescaler u_presc
  (
    .clock_i                   (clock_i),
    .rst_i                     (rst_i),
    .ce_i                      (ce_i),
    .prescale_select_i         (prescale_select_r),
    .timer_external_clock_in_i (timer_external_clock_in_i),
    .clear_i                   (clear_r),
    .tick_o                    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control register
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prescale_select_r <= `TPC_PS_RST;
      clear_r           <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        prescale_select_r <= pwdata[`TPC_PS_MSB:`TPC_PS_LSB];
        clear_r           <= pwdata[`TPC_CLR_BIT];
      end
      else
        clear_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      count_o <= `TPC_CNT_RST;
    else if (ce_i)
    begin
      // Clear is self-clearing so software needs no second write to restart counting
      if (clear_r)
        count_o <= `TPC_CNT_RST;
      else if (tick)
        count_o <= count_o + {{(`TPC_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Coherent read buffer for the low byte
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_buf_r <= `TPC_BYTE_RST;
      latched_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clear_r)
      begin
        low_buf_r <= `TPC_BYTE_RST;
        latched_r <= 1'b0;
      end
      else if (rd_hi && !latched_r)
      begin
        low_buf_r <= count_o[`TPC_LO_MSB:`TPC_LO_LSB];
        latched_r <= 1'b1;
      end
      else if (rd_lo)
        latched_r <= 1'b0;
    end
  end

  always @*
  begin
    rdata_nxt = `TPC_WORD_ZERO;
    case (paddr)
      `TPC_OFF_CTRL:   rdata_nxt[`TPC_PS_MSB:`TPC_PS_LSB] = prescale_select_r;
      `TPC_OFF_CNT_HI: rdata_nxt[`TPC_LO_MSB:`TPC_LO_LSB] = count_o[`TPC_HI_MSB:`TPC_HI_LSB];
      `TPC_OFF_CNT_LO: rdata_nxt[`TPC_LO_MSB:`TPC_LO_LSB] =
                         latched_r ? low_buf_r : count_o[`TPC_LO_MSB:`TPC_LO_LSB];
      `TPC_OFF_STATUS: rdata_nxt[`TPC_LATCH_BIT] = latched_r;
      default:         rdata_nxt = `TPC_WORD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait-free access phase, data sampled in setup
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      phase_r <= PH_IDLE;
    else if (ce_i)
      phase_r <= phase_nxt;
  end

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pready <= 1'b0;
    else if (ce_i)
      pready <= setup;
  end

  // Unmapped words answer with an error and have no other effect
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pslverr <= 1'b0;
    else if (ce_i)
      pslverr <= setup & ~mapped;
  end

  // Read data holds until the next read, so a slow master still sees it
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      prdata <= `TPC_WORD_ZERO;
    else if (ce_i)
    begin
      if (setup && !pwrite)
        prdata <= rdata_nxt;
    end
  end
endmodule // tpc_timer
`default_nettype wire

// [sim/tpc_props.sv]
// Port checker for the timer prescaler counter
`timescale 1ns/1ps
`default_nettype none
module tpc_props
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [15:0] count_o
);
  wire su = psel && !penable && ce_i;
  logic [7:0] hold_v;
  logic       held_v;
  // Reference of the captured low byte, kept from bus traffic only
  always @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      hold_v <= 8'h00;
      held_v <= 1'b0;
    end
    else if (su && !pwrite && paddr == 12'h004 && !held_v)
    begin
      hold_v <= count_o[7:0];
      held_v <= 1'b1;
    end
    else if (su && !pwrite && paddr == 12'h008)
      held_v <= 1'b0;
    else if (su && pwrite && !paddr && pstrb[0] && pwdata[3])
      held_v <= 1'b0;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_STEP: assert property ($changed(count_o) |-> count_o == $past(count_o) + 16'h0001 || !count_o)
    else $error("count jumped");
  AST_HI: assert property (su && !pwrite && paddr == 12'h004 |=> prdata == $past(count_o[15:8]))
    else $error("high byte wrong");
  // Window of two: the clear may land on either edge after the access
  AST_CLR: assert property (su && pwrite && !paddr && pstrb[0] && pwdata[3] |=> ##[1:2] !count_o)
    else $error("clear missed");
  AST_RST: assert property ($fell(rst_i) |-> count_o == 16'h0000)
    else $error("count not zero after reset");
  AST_RDY: assert property (su |=> pready ##1 !pready)
    else $error("answer not one pulse");
  AST_LO: assert property (su && !pwrite && paddr == 12'h008 && held_v |=> prdata[7:0] == hold_v)
    else $error("low byte not the captured one");
endmodule // tpc_props
bind tpc_timer tpc_props u_props (.clock_i, .rst_i, .ce_i, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .count_o);
`default_nettype wire

// [sim/tpc_timer_tb.sv]
// Self-checking bench for the timer prescaler counter
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_tb;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ext = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] count_o;
  logic [31:0] q;
  logic        e;
  logic [15:0] c0;
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  tpc_timer u_tpc_timer (.clock_i, .rst_i, .ce_i(1'b1), .timer_external_clock_in_i(ext), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .count_o);
  initial forever #4 clock_i = ~clock_i;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One idle edge after release so the next call never re-drives psel in the same step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      ext <= ~ext;
      repeat (4) @(posedge clock_i);
    end
  endtask
  // External source counts only our own pin edges, so every value below is known exactly
  task automatic t_latch;
    apb(1'b1, 12'h000, 32'h0000_000f);
    pulse(10);
    apb(1'b1, 12'h004, 32'h0000_ffff);
    apb(1'b1, 12'h008, 32'h0000_ffff);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    pulse(6);
    apb(1'b0, 12'h004, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(q, 32'h0000_0005);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(q, 32'h0000_0008);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(e, 32'h0000_0001);
  endtask
  task automatic t_scale;
    for (int n = 0; n < 7; n++)
    begin
      apb(1'b1, 12'h000, 32'h0000_0008 | n);
      // Sampled mid-cycle, once the clear and the first forced-idle tick are behind
      repeat (2) @(negedge clock_i);
      c0 = count_o;
      repeat (128) @(negedge clock_i);
      chk(count_o - c0, 32'h0000_0080 >> n);
    end
  endtask
  task automatic conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      errors++;
      conclude;
    end
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    chk(count_o, 32'h0000_0000);
    rst_i <= 1'b0;
    @(posedge clock_i);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    t_latch;
    t_scale;
    conclude;
  end
endmodule // tpc_timer_tb
`default_nettype wire
